// ==== src/dag_map.svh ====
/*
 * Constants and field encodings for the data address generator.
 * Assumes inclusion by bare name from the encoder and address generator modules.
 */
`ifndef DAG_MAP_SVH
`define DAG_MAP_SVH
`define DAG_SIZE_8 3'h0
`define DAG_SIZE_16 3'h1
`define DAG_SIZE_32 3'h2
`define DAG_SIZE_64 3'h3
`define DAG_SIZE_128 3'h4
`define DAG_BURST_INCR 2'h1
`define DAG_LOCK_NORMAL 2'h0
`define DAG_LEN_ONE 4'h0
`define DAG_LEN_TWO 4'h1
`define DAG_WIDTH_128 1'h0
`define DAG_WIDTH_64 1'h1
`define DAG_ADDR_RST 32'h0000_0000
`endif

// ==== src/dag_pkg.sv ====
/*
 * Types shared by the data address generator modules.
 * Assumes dag_map.svh is on the include path.
 */
package dag_pkg;
	// Access kinds presented by the load/store unit
	typedef enum logic [2:0] {
		DAG_KIND_WALK = 3'h0,
		DAG_KIND_BYTE = 3'h1,
		DAG_KIND_HALF = 3'h2,
		DAG_KIND_WORD = 3'h3,
		DAG_KIND_DWORD = 3'h4
	} dag_kind_t;
	// Boundary classes of an access
	typedef enum logic [2:0] {
		DAG_BC_NONE = 3'h0,
		DAG_BC_HW = 3'h1,
		DAG_BC_W = 3'h2,
		DAG_BC_DW = 3'h3,
		DAG_BC_QW = 3'h4
	} dag_bc_t;
	// Sequencer states
	typedef enum logic [2:0] {
		DAG_ST_IDLE = 3'b001,
		DAG_ST_FIRST = 3'b010,
		DAG_ST_SECOND = 3'b100
	} dag_state_t;
endpackage : dag_pkg

// ==== src/dag_cmd_if.sv ====
/*
 * Interface carrying one address-channel command between the modules.
 * Assumes a single clock domain; no timing of its own.
 */
`timescale 1ns/1ps
interface dag_cmd_if;
	logic [31:0] addr;
	logic [3:0] len;
	logic [2:0] size;
	logic two_txn;
	logic [31:0] addr2;
	modport enc (output addr, len, size, two_txn, addr2);
	modport seq (input addr, len, size, two_txn, addr2);
endinterface : dag_cmd_if

// ==== src/dag_encoder.sv ====
/*
 * Combinational classifier and encoder for one data access.
 * Assumes inputs are stable while the request is presented.
 */
`timescale 1ns/1ps
`include "dag_map.svh"
module dag_encoder (
	// Access description
	input wire dag_pkg::dag_kind_t i_kind,
	input wire logic [31:0] i_addr,
	input wire logic i_bus_width_select,
	// Encoded command
	dag_cmd_if.enc cmd
);
	// Classify an access from its size and low address bits
	function automatic dag_pkg::dag_bc_t classify(
		input dag_pkg::dag_kind_t kind, input logic [3:0] off);
		logic [4:0] last;
		last = {1'b0, off} + ((kind == dag_pkg::DAG_KIND_HALF) ?
			5'h01 : 5'h03);
		if (kind != dag_pkg::DAG_KIND_HALF &&
			kind != dag_pkg::DAG_KIND_WORD)
			classify = dag_pkg::DAG_BC_NONE;
		// Aligned first, else an aligned word looks like a halfword cross
		else if ((kind == dag_pkg::DAG_KIND_HALF) ? !off[0] :
			(off[1:0] == 2'h0))
			classify = dag_pkg::DAG_BC_NONE;
		else if (last[4])
			classify = dag_pkg::DAG_BC_QW;
		else if (last[3] != off[3])
			classify = dag_pkg::DAG_BC_DW;
		else if (last[2] != off[2])
			classify = dag_pkg::DAG_BC_W;
		else if (last[1] != off[1])
			classify = dag_pkg::DAG_BC_HW;
		else
			classify = dag_pkg::DAG_BC_NONE;
	endfunction : classify

	wire dag_pkg::dag_bc_t boundary_crossed_class;
	wire logic naturally_aligned_flag;
	wire logic [3:0] start_offset_low_bits;
	wire logic is_half;
	wire logic bus64;
	wire logic [31:0] a_hw;
	wire logic [31:0] a_w;
	wire logic [31:0] a_dw;
	wire logic [31:0] a_qw;

	// Address forms and class
	assign start_offset_low_bits = i_addr[3:0];
	assign boundary_crossed_class = classify(i_kind,
		start_offset_low_bits);
	assign naturally_aligned_flag =
		(boundary_crossed_class == dag_pkg::DAG_BC_NONE);
	assign is_half = (i_kind == dag_pkg::DAG_KIND_HALF);
	assign bus64 = (i_bus_width_select == `DAG_WIDTH_64);
	assign a_hw = {i_addr[31:1], 1'h0};
	assign a_w = {i_addr[31:2], 2'h0};
	assign a_dw = {i_addr[31:3], 3'h0};
	assign a_qw = {i_addr[31:4], 4'h0};
	assign cmd.addr2 = a_qw + 32'h0000_0010;

	// Encoding selection
	always_comb begin
		cmd.addr = a_w;
		cmd.len = `DAG_LEN_ONE;
		cmd.size = `DAG_SIZE_32;
		cmd.two_txn = 1'b0;
		if (naturally_aligned_flag) begin
			unique case (i_kind)
				dag_pkg::DAG_KIND_WALK: begin
					cmd.addr = a_w;
					cmd.size = `DAG_SIZE_32;
				end
				dag_pkg::DAG_KIND_BYTE: begin
					cmd.addr = i_addr;
					cmd.size = `DAG_SIZE_8;
				end
				dag_pkg::DAG_KIND_HALF: begin
					cmd.addr = a_hw;
					cmd.size = `DAG_SIZE_16;
				end
				dag_pkg::DAG_KIND_WORD: begin
					cmd.addr = a_w;
					cmd.size = `DAG_SIZE_32;
				end
				default: begin
					cmd.addr = a_dw;
					cmd.size = `DAG_SIZE_64;
				end
			endcase
		end else begin
			unique case (boundary_crossed_class)
				dag_pkg::DAG_BC_QW: begin
					cmd.two_txn = 1'b1;
					cmd.addr = is_half ? a_hw : a_w;
					cmd.size = is_half ? `DAG_SIZE_16 : `DAG_SIZE_32;
				end
				dag_pkg::DAG_BC_DW: begin
					if (bus64) begin
						cmd.addr = is_half ? a_hw : a_w;
						cmd.len = `DAG_LEN_TWO;
						cmd.size = is_half ? `DAG_SIZE_16 : `DAG_SIZE_32;
					end else begin
						cmd.addr = a_qw;
						cmd.size = `DAG_SIZE_128;
					end
				end
				dag_pkg::DAG_BC_W: begin
					cmd.addr = a_dw;
					cmd.size = `DAG_SIZE_64;
				end
				default: begin
					cmd.addr = a_w;
					cmd.size = `DAG_SIZE_32;
				end
			endcase
		end
	end
endmodule : dag_encoder

// ==== src/dag_addr_gen.sv ====
/*
 * Data address generator: takes one access request, issues one or two
 * address-channel commands with a valid/ready handshake.
 * Assumes the width select pin is static and the slave obeys valid/ready.
 */
`timescale 1ns/1ps
`include "dag_map.svh"
module dag_addr_gen (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Configuration pin
	input wire logic i_bus_width_select,
	// Access request
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire dag_pkg::dag_kind_t i_req_kind,
	input wire logic [31:0] i_req_addr,
	// Address channel
	output logic o_ax_valid,
	input wire logic i_ax_ready,
	output logic [31:0] o_ax_addr,
	output logic [3:0] o_ax_len,
	output logic [2:0] o_ax_size,
	output logic [1:0] o_ax_burst,
	output logic [1:0] o_ax_lock,
	output logic o_ax_last
);
	dag_cmd_if cmd ();
	dag_pkg::dag_state_t state_reg;
	dag_pkg::dag_state_t state_next;
	logic [1:0] width_sync_reg;
	logic width_reg;
	logic [31:0] addr2_reg;
	logic [31:0] addr_reg;
	logic [3:0] len_reg;
	logic [2:0] size_reg;
	logic two_reg;
	logic transaction_sequence_index;
	wire logic take;
	wire logic done;

	/////////////////////////////////////////////////////////////////////
	// Width select pin synchroniser; third stage (width_reg) feeds the encoder
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			width_sync_reg <= 2'h0;
			width_reg <= 1'h0;
		end else begin
			width_sync_reg <= {width_sync_reg[0], i_bus_width_select};
			width_reg <= width_sync_reg[1];
		end
	end

	dag_encoder u_enc (
		.i_kind(i_req_kind),
		.i_addr(i_req_addr),
		.i_bus_width_select(width_reg),
		.cmd(cmd)
	);

	/////////////////////////////////////////////////////////////////////
	// Handshake terms
	assign o_req_ready = (state_reg == dag_pkg::DAG_ST_IDLE);
	assign take = i_req_valid && o_req_ready;
	assign done = o_ax_valid && i_ax_ready;
	assign transaction_sequence_index = (state_reg == dag_pkg::DAG_ST_SECOND);

	// Next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			dag_pkg::DAG_ST_IDLE:
				if (take)
					state_next = dag_pkg::DAG_ST_FIRST;
			dag_pkg::DAG_ST_FIRST:
				if (done)
					state_next = two_reg ? dag_pkg::DAG_ST_SECOND :
						dag_pkg::DAG_ST_IDLE;
			dag_pkg::DAG_ST_SECOND:
				if (done)
					state_next = dag_pkg::DAG_ST_IDLE;
			default:
				state_next = dag_pkg::DAG_ST_IDLE;
		endcase
	end

	/////////////////////////////////////////////////////////////////////
	// State and command registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= dag_pkg::DAG_ST_IDLE;
			addr_reg <= `DAG_ADDR_RST;
			addr2_reg <= `DAG_ADDR_RST;
			len_reg <= `DAG_LEN_ONE;
			size_reg <= `DAG_SIZE_8;
			two_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (take) begin
				addr_reg <= cmd.addr;
				addr2_reg <= cmd.addr2;
				len_reg <= cmd.len;
				size_reg <= cmd.size;
				two_reg <= cmd.two_txn;
			end else if (done && state_reg == dag_pkg::DAG_ST_FIRST &&
				two_reg) begin
				addr_reg <= addr2_reg;
			end
		end
	end

	/////////////////////////////////////////////////////////////////////
	// Address channel outputs
	assign o_ax_valid = (state_reg != dag_pkg::DAG_ST_IDLE);
	assign o_ax_addr = addr_reg;
	assign o_ax_len = len_reg;
	assign o_ax_size = size_reg;
	assign o_ax_burst = `DAG_BURST_INCR;
	assign o_ax_lock = `DAG_LOCK_NORMAL;
	assign o_ax_last = transaction_sequence_index || !two_reg;
endmodule : dag_addr_gen

// ==== bench/dag_slave_model.sv ====
/* Address-channel slave model: ready level with random stalls.
 * Assumes the bench supplies a stall request each cycle. */
`timescale 1ns/1ps
module dag_slave_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Channel
	input wire logic i_stall,
	output logic o_ax_ready
);
	// Registered ready, low in reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ax_ready <= 1'b0;
		end else begin
			o_ax_ready <= !i_stall;
		end
	end
endmodule : dag_slave_model

// ==== bench/dag_addr_gen_sva.sv ====
/* Checker on the dag_addr_gen ports.
 * Assumes one clock and the bind below. */
`timescale 1ns/1ps
module dag_addr_gen_sva (
	// Clock, reset, pin
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_bus_width_select,
	// Request
	input wire logic i_req_valid,
	input wire logic o_req_ready,
	input wire dag_pkg::dag_kind_t i_req_kind,
	input wire logic [31:0] i_req_addr,
	// Address channel
	input wire logic o_ax_valid,
	input wire logic i_ax_ready,
	input wire logic [31:0] o_ax_addr,
	input wire logic [3:0] o_ax_len,
	input wire logic [2:0] o_ax_size,
	input wire logic [1:0] o_ax_burst,
	input wire logic [1:0] o_ax_lock,
	input wire logic o_ax_last
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Request take and channel handshake
	wire take = i_req_valid && o_req_ready;
	wire hs = o_ax_valid && i_ax_ready;
	a_burst_lock: assert property (o_ax_valid |->
		o_ax_burst == 2'h1 && o_ax_lock == 2'h0) else $error("bad burst");
	a_answer_next: assert property (take |=>
		o_ax_valid && !o_req_ready) else $error("no command");
	a_hold_stall: assert property (o_ax_valid && !i_ax_ready |=>
		o_ax_valid && $stable(o_ax_addr)) else $error("not held");
	a_byte_full: assert property (take && i_req_kind == 3'h1 |=>
		o_ax_addr == $past(i_req_addr) && o_ax_size == 3'h0)
		else $error("byte wrong");
	a_walk_word: assert property (take && i_req_kind == 3'h0 |=>
		o_ax_addr[1:0] == 2'h0 && o_ax_size == 3'h2 && o_ax_last)
		else $error("walk wrong");
	a_dword_one: assert property (take && i_req_kind == 3'h4 |=>
		o_ax_addr[2:0] == 3'h0 && o_ax_size == 3'h3 && o_ax_len == 4'h0)
		else $error("dword wrong");
	a_split_second: assert property (hs && !o_ax_last |=>
		o_ax_valid && o_ax_last && o_ax_addr[3:0] == 4'h0 &&
		$stable(o_ax_size)) else $error("second wrong");
	a_len_narrow: assert property (o_ax_valid && o_ax_len == 4'h1 |->
		i_bus_width_select) else $error("len on wide bus");
	a_quad_wide: assert property (o_ax_valid && o_ax_size == 3'h4 |->
		!i_bus_width_select && o_ax_addr[3:0] == 4'h0)
		else $error("quad wrong");
	a_idle_after: assert property (hs && o_ax_last |=>
		!o_ax_valid && o_req_ready) else $error("not idle");
	// Main scenarios
	c_split: cover property (hs && !o_ax_last);
	c_len_two: cover property (hs && o_ax_len == 4'h1);
	c_quad: cover property (hs && o_ax_size == 3'h4);
endmodule : dag_addr_gen_sva
bind dag_addr_gen dag_addr_gen_sva u_sva (.*);

// ==== bench/dag_addr_gen_tb.sv ====
/* Testbench for dag_addr_gen: directed and random loads, both widths.
 * Assumes the slave model and checker are compiled before it. */
`timescale 1ns/1ps
module dag_addr_gen_tb;
	logic i_clk = 1'b0, i_rst_n = 1'b0, w = 1'b1, rv = 1'b0, stall = 1'b0;
	dag_pkg::dag_kind_t kind = dag_pkg::DAG_KIND_WALK;
	logic [31:0] addr = 32'h0, r, aa;
	logic rdy, av, ar, alast;
	logic [3:0] al;
	logic [2:0] az;
	logic [1:0] ab, ak;
	logic [43:0] exp_q [$];
	logic [43:0] sn, ex;
	integer seed = 67, fail_count = 0, num_checks = 0;
	logic [6:0] tbl [0:12] = '{7'h03, 7'h15, 7'h20, 7'h2F, 7'h27, 7'h23,
		7'h21, 7'h30, 7'h3D, 7'h35, 7'h32, 7'h48, 7'h3F};
	// Clock
	initial forever #2.5 i_clk = ~i_clk;
	dag_addr_gen dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_bus_width_select(w), .i_req_valid(rv), .o_req_ready(rdy),
		.i_req_kind(kind), .i_req_addr(addr), .o_ax_valid(av),
		.i_ax_ready(ar), .o_ax_addr(aa), .o_ax_len(al), .o_ax_size(az),
		.o_ax_burst(ab), .o_ax_lock(ak), .o_ax_last(alast));
	dag_slave_model slv (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_stall(stall), .o_ax_ready(ar));
	task chk(input logic [43:0] seen, input logic [43:0] want);
		num_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask : chk
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task push(input logic [31:0] a, input logic [3:0] l,
		input logic [2:0] s, input logic t);
		exp_q.push_back({a, l, s, t, 2'h1, 2'h0});
	endtask : push
	// Expected commands from kind, offset class and width
	task expect_req(input logic [2:0] k, input logic [31:0] a);
		logic [31:0] m;
		logic [4:0] e;
		logic [3:0] d;
		m = (k == 3'h2) ? 32'h1 : 32'h3;
		e = {1'b0, a[3:0]} + m[4:0];
		d = a[3:0] ^ e[3:0];
		if (k == 3'h0) push(a & ~32'h3, 4'h0, 3'h2, 1'b1);
		else if (k == 3'h1) push(a, 4'h0, 3'h0, 1'b1);
		else if (k == 3'h4) push(a & ~32'h7, 4'h0, 3'h3, 1'b1);
		else if ((a & m) == 32'h0) push(a & ~m, 4'h0, k - 3'h1, 1'b1);
		else if (e[4]) begin
			push(a & ~m, 4'h0, k - 3'h1, 1'b0);
			push({a[31:4] + 28'h1, 4'h0}, 4'h0, k - 3'h1, 1'b1);
		end else if (d[3] && w) push(a & ~m, 4'h1, k - 3'h1, 1'b1);
		else if (d[3]) push(a & ~32'hF, 4'h0, 3'h4, 1'b1);
		else if (d[2]) push(a & ~32'h7, 4'h0, 3'h3, 1'b1);
		else push(a & ~32'h3, 4'h0, 3'h2, 1'b1);
	endtask : expect_req
	task send(input logic [2:0] k, input logic [31:0] a);
		@(negedge i_clk);
		while (rdy !== 1'b1) @(negedge i_clk);
		@(posedge i_clk);
		rv <= 1'b1;
		kind <= dag_pkg::dag_kind_t'(k);
		addr <= a;
		@(posedge i_clk);
		rv <= 1'b0;
		expect_req(k, a);
	endtask : send
	// Slave stalls
	always @(posedge i_clk) stall <= ($random(seed) % 4) == 0;
	// Monitor: each accepted command against the oldest note
	always @(posedge i_clk) if (av && ar) begin
		sn = {aa, al, az, alast, ab, ak};
		ex = (exp_q.size() != 0) ? exp_q.pop_front() : ~sn;
		chk(sn, ex);
	end
	// Main sequence over both widths
	initial begin
		repeat (5) @(posedge i_clk);
		// Reset levels of the channel and the request side
		@(negedge i_clk);
		chk({aa, al, az, alast, ab, ak}, {39'h0, 5'h14});
		chk({42'h0, rdy, av}, {42'h0, 2'h2});
		$display("test reset levels done");
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			while (exp_q.size() != 0) @(posedge i_clk);
			w <= (p == 0);
			repeat (4) @(posedge i_clk);
			for (int i = 0; i < 13; i++) begin
				r = $random(seed);
				send(tbl[i][6:4], {r[31:4], tbl[i][3:0]});
			end
			repeat (30) begin
				r = $random(seed);
				send(r[2:0] % 3'h5, r);
			end
			$display("test width pass %0d done", p);
		end
		repeat (20) @(posedge i_clk);
		// Every noted command must have been issued
		chk(44'(exp_q.size()), 44'h0);
		summarize();
	end
	// Watchdog
	initial begin
		#50000;
		fail_count++;
		summarize();
	end
endmodule : dag_addr_gen_tb
